// ===== logic/flash_block_command_engine.sv
// The implementer's own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
//
// Contract
// - erase reply carries code 0x81
// - status bit zero flags failure, others reserved
// - replies echo block index and offset
// - erase/program replies: count zero, no payload
// - unicast reply goes to requester source endpoint
// - decode 0x02 program, 0x03 erase-then-program
// - erase-then-program erases block before programming
// - program reply 0x82, erase-then-program 0x83
// - readback code 0x04, count bytes wanted
// - readback reply 0x84, count equals payload
// - readback payload from block at offset
// - program stores payload from given offset
// - fixed reply byte layout, big-endian fields
// - erase sets ones, program only clears
// - no reply to broadcast frames
module flash_block_command_engine #(
    parameter int NUM_BLOCKS = 4,
    parameter int BLOCK_SIZE = 64
) (
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_last,
    input  wire logic        rx_broadcast,
    input  wire logic [7:0]  rx_src_endpoint,
    output logic             rx_ready,
    output logic             tx_valid,
    output logic [7:0]       tx_data,
    output logic             tx_last,
    output logic [7:0]       tx_dest_endpoint,
    input  wire logic        tx_ready
);

    localparam int TOTAL  = NUM_BLOCKS * BLOCK_SIZE;
    localparam int ADDR_W = $clog2(TOTAL);

    // ==============================================================
    // state and registers
    flash_cmd_pkg::state_t state;
    flash_cmd_pkg::state_t next_state;

    logic [2:0]              hdr_idx;
    logic [7:0]              cmd;
    logic [15:0]             blk;
    logic [15:0]             off;
    logic [15:0]             cnt;
    logic [7:0]              src_ep;
    logic                    bcast;
    logic                    frame_done;
    logic                    err;
    logic                    reply_en;
    logic                    erased;
    logic [ADDR_W-1:0]       cur_addr;
    logic [ADDR_W-1:0]       end_addr;
    logic [15:0]             left;
    logic [7:0]              hold;
    logic [flash_cmd_pkg::POS_W-1:0] idx;
    logic                    enable;
    logic [31:0]             done_count;
    logic [7:0]              mem_rdata;

    // ==============================================================
    // decode of the captured header
    wire accept      = rx_valid && rx_ready;
    wire is_erase    = (cmd == flash_cmd_pkg::CMD_ERASE);
    wire is_prog     = (cmd == flash_cmd_pkg::CMD_PROGRAM);
    wire is_etp      = (cmd == flash_cmd_pkg::CMD_ERASE_PROGRAM);
    wire is_read     = (cmd == flash_cmd_pkg::CMD_READBACK);
    wire known       = is_erase || is_prog || is_etp || is_read;
    wire blk_ok      = (32'(blk) < 32'(NUM_BLOCKS));
    wire range_ok    = ((17'(off) + 17'(cnt)) <= 17'(BLOCK_SIZE));
    wire erase_all   = is_erase && (cnt == 16'h0000);
    // erase only checks the block, and not even that when count is zero (erase all); the others also the byte range
    wire chk_err     = is_erase ? (!erase_all && !blk_ok) : !(blk_ok && range_ok);
    wire go_erase    = known && !chk_err && (is_erase || is_etp);
    wire go_prog     = known && !chk_err && is_prog && (cnt != 16'h0000) && !frame_done;
    wire etp_prog    = is_etp && (cnt != 16'h0000) && !frame_done;
    wire [ADDR_W-1:0] blk_base  = ADDR_W'(32'(blk) * 32'(BLOCK_SIZE));
    wire [ADDR_W-1:0] start     = blk_base + ADDR_W'(off);
    wire [ADDR_W-1:0] ers_first = erase_all ? '0 : blk_base;
    wire [ADDR_W-1:0] ers_last  = erase_all ? ADDR_W'(TOTAL - 1)
                                            : blk_base + ADDR_W'(BLOCK_SIZE - 1);
    wire flash_state = (state == flash_cmd_pkg::S_ERASE) ||
                       (state == flash_cmd_pkg::S_PRG_WR);
    flash_cmd_pkg::state_t post_state;
    assign post_state = frame_done ? flash_cmd_pkg::S_REPLY : flash_cmd_pkg::S_DRAIN;

    // ==============================================================
    // reply byte selection
    wire        reply_read = is_read && !err;
    wire [15:0] reply_cnt  = reply_read ? cnt : 16'h0000;
    wire        reply_last = (idx == (flash_cmd_pkg::POS_LAST_HDR + 17'(reply_cnt)));
    logic [7:0] reply_byte;
    always_comb begin
        reply_byte = mem_rdata;
        if (idx < flash_cmd_pkg::POS_PAYLOAD) begin
            case (idx[2:0])
                flash_cmd_pkg::POS_CODE:     reply_byte = cmd | flash_cmd_pkg::REPLY_FLAG;
                flash_cmd_pkg::POS_STATUS:   reply_byte = {7'h00, err};
                flash_cmd_pkg::POS_BLOCK_HI: reply_byte = blk[15:8];
                flash_cmd_pkg::POS_BLOCK_LO: reply_byte = blk[7:0];
                flash_cmd_pkg::POS_OFF_HI:   reply_byte = off[15:8];
                flash_cmd_pkg::POS_OFF_LO:   reply_byte = off[7:0];
                flash_cmd_pkg::POS_CNT_HI:   reply_byte = reply_cnt[15:8];
                default:                     reply_byte = reply_cnt[7:0];
            endcase
        end
    end

    // ==============================================================
    // flash array port
    wire             mem_we    = flash_state;
    wire [7:0]       mem_wdata = (state == flash_cmd_pkg::S_ERASE) ? flash_cmd_pkg::ERASED_BYTE
                                                                    : (mem_rdata & hold);
    flash_store_mem #(
        .DEPTH  (TOTAL),
        .ADDR_W (ADDR_W)
    ) u_store (
        .clock (clock),
        .we    (mem_we),
        .addr  (cur_addr),
        .wdata (mem_wdata),
        .rdata (mem_rdata)
    );

    // ==============================================================
    // sequencing
    always_comb begin
        next_state = state;
        case (state)
            flash_cmd_pkg::S_HDR: begin
                if (accept && hdr_idx == flash_cmd_pkg::POS_CNT_LO) begin
                    next_state = flash_cmd_pkg::S_CHECK;
                end
            end
            flash_cmd_pkg::S_CHECK: begin
                if (go_erase) begin
                    next_state = flash_cmd_pkg::S_ERASE;
                end else if (go_prog) begin
                    next_state = flash_cmd_pkg::S_PRG_TAKE;
                end else begin
                    next_state = post_state;
                end
            end
            flash_cmd_pkg::S_ERASE: begin
                // programming only starts once the last erase write is done
                if (cur_addr == end_addr) begin
                    next_state = etp_prog ? flash_cmd_pkg::S_PRG_TAKE : post_state;
                end
            end
            flash_cmd_pkg::S_PRG_TAKE: begin
                if (accept) begin
                    next_state = flash_cmd_pkg::S_PRG_WR;
                end
            end
            flash_cmd_pkg::S_PRG_WR: begin
                if (frame_done) begin
                    next_state = flash_cmd_pkg::S_REPLY;
                end else if (left == 16'h0001) begin
                    next_state = flash_cmd_pkg::S_DRAIN;
                end else begin
                    next_state = flash_cmd_pkg::S_PRG_TAKE;
                end
            end
            flash_cmd_pkg::S_DRAIN: begin
                if (accept && rx_last) begin
                    next_state = flash_cmd_pkg::S_REPLY;
                end
            end
            flash_cmd_pkg::S_REPLY: begin
                next_state = reply_en ? flash_cmd_pkg::S_TX_LOAD : flash_cmd_pkg::S_HDR;
            end
            flash_cmd_pkg::S_TX_LOAD: next_state = flash_cmd_pkg::S_TX_WAIT;
            flash_cmd_pkg::S_TX_WAIT: begin
                if (tx_ready) begin
                    if (tx_last) begin
                        next_state = flash_cmd_pkg::S_HDR;
                    end else if (reply_read && idx >= flash_cmd_pkg::POS_LAST_HDR) begin
                        next_state = flash_cmd_pkg::S_RD_FETCH;
                    end else begin
                        next_state = flash_cmd_pkg::S_TX_LOAD;
                    end
                end
            end
            flash_cmd_pkg::S_RD_FETCH: next_state = flash_cmd_pkg::S_TX_LOAD;
            default: next_state = flash_cmd_pkg::S_HDR;
        endcase
    end

    wire next_ready = ((next_state == flash_cmd_pkg::S_HDR) && enable) ||
                      (next_state == flash_cmd_pkg::S_PRG_TAKE) ||
                      (next_state == flash_cmd_pkg::S_DRAIN);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state    <= flash_cmd_pkg::S_HDR;
            rx_ready <= 1'b0;
        end else begin
            state    <= next_state;
            rx_ready <= next_ready;
        end
    end

    // ==============================================================
    // header capture
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            hdr_idx <= 3'h0;
            cmd     <= 8'h00;
            blk     <= 16'h0000;
            off     <= 16'h0000;
            cnt     <= 16'h0000;
            src_ep  <= 8'h00;
            bcast   <= 1'b0;
        end else if (state == flash_cmd_pkg::S_HDR && accept) begin
            // a frame ending inside the header is dropped silently
            hdr_idx <= rx_last ? 3'h0 : hdr_idx + 3'h1;
            case (hdr_idx)
                flash_cmd_pkg::POS_CODE: begin
                    cmd    <= rx_data;
                    src_ep <= rx_src_endpoint;
                    bcast  <= rx_broadcast;
                end
                flash_cmd_pkg::POS_BLOCK_HI: blk[15:8] <= rx_data;
                flash_cmd_pkg::POS_BLOCK_LO: blk[7:0]  <= rx_data;
                flash_cmd_pkg::POS_OFF_HI:   off[15:8] <= rx_data;
                flash_cmd_pkg::POS_OFF_LO:   off[7:0]  <= rx_data;
                flash_cmd_pkg::POS_CNT_HI:   cnt[15:8] <= rx_data;
                flash_cmd_pkg::POS_CNT_LO:   cnt[7:0]  <= rx_data;
                default: ;
            endcase
        end
    end

    // ==============================================================
    // operation datapath
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            frame_done <= 1'b0;
            err        <= 1'b0;
            reply_en   <= 1'b0;
            erased     <= 1'b0;
            cur_addr   <= '0;
            end_addr   <= '0;
            left       <= 16'h0000;
            hold       <= 8'h00;
        end else begin
            // a frame cut inside the header must not mark the next frame done
            if (accept && rx_last && !(state == flash_cmd_pkg::S_HDR &&
                                       hdr_idx != flash_cmd_pkg::POS_CNT_LO)) begin
                frame_done <= 1'b1;
            end else if (state == flash_cmd_pkg::S_REPLY) begin
                frame_done <= 1'b0;
            end
            case (state)
                flash_cmd_pkg::S_CHECK: begin
                    err      <= chk_err || !known;
                    reply_en <= known && !bcast;
                    erased   <= 1'b0;
                    left     <= cnt;
                    cur_addr <= go_erase ? ers_first : start;
                    end_addr <= ers_last;
                end
                flash_cmd_pkg::S_ERASE: begin
                    cur_addr <= (cur_addr == end_addr) ? start : cur_addr + 1'b1;
                    erased   <= (cur_addr == end_addr);
                end
                flash_cmd_pkg::S_PRG_TAKE: hold <= rx_data;
                flash_cmd_pkg::S_PRG_WR: begin
                    cur_addr <= cur_addr + 1'b1;
                    left     <= left - 16'h0001;
                end
                flash_cmd_pkg::S_REPLY:    cur_addr <= start;
                flash_cmd_pkg::S_RD_FETCH: cur_addr <= cur_addr + 1'b1;
                default: ;
            endcase
        end
    end

    // ==============================================================
    // reply stream
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tx_valid         <= 1'b0;
            tx_data          <= 8'h00;
            tx_last          <= 1'b0;
            tx_dest_endpoint <= 8'h00;
            idx              <= '0;
        end else if (state == flash_cmd_pkg::S_REPLY) begin
            idx              <= '0;
            tx_dest_endpoint <= src_ep;
        end else if (state == flash_cmd_pkg::S_TX_LOAD) begin
            tx_valid <= 1'b1;
            tx_data  <= reply_byte;
            tx_last  <= reply_last;
        end else if (state == flash_cmd_pkg::S_TX_WAIT && tx_ready) begin
            tx_valid <= 1'b0;
            tx_last  <= 1'b0;
            idx      <= idx + 1'b1;
        end
    end

    // ==============================================================
    // wishbone slave: ctrl, status, done counter, geometry
    wire        wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire        busy   = (state != flash_cmd_pkg::S_HDR) || (hdr_idx != 3'h0);
    logic [31:0] rd_mux;
    always_comb begin
        case (wb_adr_i)
            flash_cmd_pkg::REG_CTRL:     rd_mux = {31'h0, enable};
            flash_cmd_pkg::REG_STATUS:   rd_mux = {30'h0, err, busy};
            flash_cmd_pkg::REG_DONE:     rd_mux = done_count;
            flash_cmd_pkg::REG_GEOMETRY: rd_mux = {16'(NUM_BLOCKS), 16'(BLOCK_SIZE)};
            default:                     rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wb_ack_o   <= 1'b0;
            wb_dat_o   <= 32'h0;
            enable     <= flash_cmd_pkg::CTRL_ENABLE_RESET;
            done_count <= 32'h0;
        end else begin
            wb_ack_o <= wb_hit;
            wb_dat_o <= wb_hit ? rd_mux : 32'h0;
            if (wb_hit && wb_we_i && wb_sel_i[0] && wb_adr_i == flash_cmd_pkg::REG_CTRL) begin
                enable <= wb_dat_i[0];
            end
            if (state == flash_cmd_pkg::S_REPLY) begin
                done_count <= done_count + 32'h1;
            end
        end
    end

    // ==============================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    AST_ERASE_CODE: assert property (
        state == flash_cmd_pkg::S_TX_WAIT && idx == '0 && is_erase |-> tx_data == 8'h81)
        else $error("erase reply code wrong");
    AST_STATUS_RSVD: assert property (
        state == flash_cmd_pkg::S_TX_WAIT && idx == 17'h1 |-> tx_data == {7'h00, err})
        else $error("status byte wrong");
    AST_ECHO_BLOCK: assert property (
        state == flash_cmd_pkg::S_TX_WAIT && idx == 17'h2 |-> tx_data == blk[15:8])
        else $error("block index not echoed");
    AST_ZERO_COUNT: assert property (
        tx_valid && !is_read && idx == 17'h7 |-> tx_data == 8'h00 && tx_last)
        else $error("nonzero count in erase or program reply");
    AST_DEST: assert property (
        $rose(tx_valid) |-> tx_dest_endpoint == src_ep)
        else $error("reply not sent to source endpoint");
    AST_ETP_ORDER: assert property (
        state == flash_cmd_pkg::S_PRG_WR && is_etp |-> erased)
        else $error("program before erase completed");
    AST_PROG_CODE: assert property (
        state == flash_cmd_pkg::S_TX_WAIT && idx == '0 && (is_prog || is_etp)
        |-> tx_data == (is_prog ? 8'h82 : 8'h83))
        else $error("program reply code wrong");
    AST_READ_LEN: assert property (
        tx_valid && tx_last && reply_read |-> idx == 17'(cnt) + 17'h7)
        else $error("readback length mismatch");
    AST_CLEAR_ONLY: assert property (
        state == flash_cmd_pkg::S_PRG_WR |-> (mem_wdata & ~mem_rdata) == 8'h00)
        else $error("program set a bit");
    AST_NO_BCAST: assert property (
        state == flash_cmd_pkg::S_REPLY && bcast |=> !tx_valid [*2])
        else $error("reply to broadcast");
    AST_ERR_SKIP: assert property (
        state == flash_cmd_pkg::S_CHECK && chk_err |=> !mem_we [*2])
        else $error("flash touched on bad request");

endmodule

// ===== logic/flash_cmd_pkg.sv
package flash_cmd_pkg;

    // ==============================================================
    // command and reply codes
    localparam logic [7:0] CMD_ERASE         = 8'h01;
    localparam logic [7:0] CMD_PROGRAM       = 8'h02;
    localparam logic [7:0] CMD_ERASE_PROGRAM = 8'h03;
    localparam logic [7:0] CMD_READBACK      = 8'h04;
    localparam logic [7:0] REPLY_FLAG        = 8'h80;
    localparam logic [7:0] ERASED_BYTE       = 8'hff;

    // ==============================================================
    // frame layout, byte positions (two-byte fields big-endian)
    localparam logic [2:0] POS_CODE     = 3'h0;
    localparam logic [2:0] POS_STATUS   = 3'h1;
    localparam logic [2:0] POS_BLOCK_HI = 3'h2;
    localparam logic [2:0] POS_BLOCK_LO = 3'h3;
    localparam logic [2:0] POS_OFF_HI   = 3'h4;
    localparam logic [2:0] POS_OFF_LO   = 3'h5;
    localparam logic [2:0] POS_CNT_HI   = 3'h6;
    localparam logic [2:0] POS_CNT_LO   = 3'h7;
    localparam int         POS_W        = 17;
    localparam logic [16:0] POS_PAYLOAD = 17'h00008;
    localparam logic [16:0] POS_LAST_HDR = 17'h00007;

    // ==============================================================
    // register map, byte addresses
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_STATUS   = 8'h04;
    localparam logic [7:0] REG_DONE     = 8'h08;
    localparam logic [7:0] REG_GEOMETRY = 8'h0c;
    localparam logic       CTRL_ENABLE_RESET = 1'b1;

    // ==============================================================
    // engine states
    typedef enum logic [9:0] {
        S_HDR      = 10'h001,
        S_CHECK    = 10'h002,
        S_ERASE    = 10'h004,
        S_PRG_TAKE = 10'h008,
        S_PRG_WR   = 10'h010,
        S_DRAIN    = 10'h020,
        S_REPLY    = 10'h040,
        S_RD_FETCH = 10'h080,
        S_TX_LOAD  = 10'h100,
        S_TX_WAIT  = 10'h200
    } state_t;

endpackage

// ===== logic/flash_store_mem.sv
`timescale 1ns/1ps
module flash_store_mem #(
    parameter int DEPTH  = 256,
    parameter int ADDR_W = 8
) (
    input  wire logic              clock,
    input  wire logic              we,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [7:0]        wdata,
    output logic      [7:0]        rdata
);

    // ==============================================================
    // byte array, read data registered; no reset so it maps to ram
    logic [7:0] cells [DEPTH];

    always_ff @(posedge clock) begin
        if (we) begin
            cells[addr] <= wdata;
        end
        rdata <= cells[addr];
    end

endmodule

// ===== bench/requester_node.sv
`timescale 1ns/1ps
// ==========================================
// remote requester: sends command frames, sinks replies
module requester_node (
    input  wire logic       clock,
    input  wire logic       slow,
    input  wire logic       rx_ready,
    input  wire logic       tx_valid,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            rx_last,
    output logic            rx_broadcast,
    output logic [7:0]      rx_src_endpoint,
    output logic            tx_ready,
    output logic            timed_out
);
    integer      seed = 32'h905d;
    logic [31:0] rnd;

    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_last = 1'b0;
        rx_broadcast = 1'b0;
        rx_src_endpoint = 8'h00;
        tx_ready = 1'b1;
        timed_out = 1'b0;
    end

    // slow sink stalls at random, to stretch reply hold times
    always @(posedge clock) begin
        rnd = $random(seed);
        tx_ready <= rnd[0] | ~slow;
    end

    task automatic send_byte(input logic [7:0] b, input logic last);
        int n;
        n = 0;
        rx_valid <= 1'b1;
        rx_data <= b;
        rx_last <= last;
        do begin
            @(posedge clock);
            n++;
        end while (rx_ready !== 1'b1 && n < 2000);
        if (n >= 2000) timed_out <= 1'b1;
    endtask

    task automatic send_frame(input logic bc, input logic [7:0] src, code,
                              input logic [15:0] blk, off, cnt, input logic [7:0] pl[$]);
        logic [7:0] hdr[8];
        hdr = '{code, 8'h00, blk[15:8], blk[7:0], off[15:8], off[7:0], cnt[15:8], cnt[7:0]};
        rx_broadcast <= bc;
        rx_src_endpoint <= src;
        for (int i = 0; i < 8; i++) send_byte(hdr[i], i == 7 && pl.size() == 0);
        foreach (pl[i]) send_byte(pl[i], i == pl.size() - 1);
        rx_valid <= 1'b0;
        // released line must not keep showing the last byte
        rx_data <= ~rx_data;
    endtask
endmodule

// ===== bench/tb.sv
`timescale 1ns/1ps
// ==========================================
// bench: frames through the engine, replies checked from a queue
module tb;
    logic        clock, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, slow, timed_out;
    logic [7:0]  wb_adr_i, rx_data, rx_src_endpoint, tx_data, tx_dest_endpoint;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, r, d;
    logic        rx_valid, rx_last, rx_broadcast, rx_ready, tx_valid, tx_last, tx_ready;
    logic [16:0] exp_q[$];
    logic [7:0]  rd[$];
    int          n_fail = 0;
    int          cmp_count = 0;
    int          done_n = 0;
    integer      seed = 32'h905d;

    flash_block_command_engine #(.NUM_BLOCKS(4), .BLOCK_SIZE(64)) i_flash_block_command_engine (
        .clock, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .rx_valid, .rx_data, .rx_last, .rx_broadcast, .rx_src_endpoint,
        .rx_ready, .tx_valid, .tx_data, .tx_last, .tx_dest_endpoint, .tx_ready);
    requester_node i_requester_node (.clock, .slow, .rx_ready, .tx_valid, .rx_valid, .rx_data,
        .rx_last, .rx_broadcast, .rx_src_endpoint, .tx_ready, .timed_out);

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic test_done;
        $display("compares %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check_reg(input string what, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            $display("unexpected %s: expected %h, seen %h", what, e, g);
            n_fail++;
        end
    endtask

    task automatic check_reply(input logic [16:0] e, g);
        cmp_count++;
        if (g !== e) begin
            $display("unexpected reply byte: expected %h, seen %h", e, g);
            n_fail++;
        end
    endtask

    always @(posedge clock) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1)
            check_reply(exp_q.size() ? exp_q.pop_front() : 17'hx, {tx_last, tx_dest_endpoint, tx_data});
    end

    always @(posedge timed_out) begin
        n_fail++;
        test_done;
    end

    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                      output logic [31:0] q);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        do begin
            @(posedge clock);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clock);
        if (n >= 50) begin
            n_fail++;
            test_done;
        end
    endtask

    // expected reply queued first; completion seen through the done counter
    task automatic frame(input logic bc, input logic [7:0] code, input logic [15:0] blk, off,
                         cnt, input logic [7:0] pl[$], input logic err, input logic [7:0] q[$]);
        logic [7:0] src;
        logic [7:0] h[8];
        int         n;
        src = 8'($random(seed));
        h = '{code | 8'h80, {7'h0, err}, blk[15:8], blk[7:0], off[15:8], off[7:0], 8'h00,
              8'(q.size())};
        if (!bc)
            for (int i = 0; i < 8 + q.size(); i++)
                exp_q.push_back({i == 7 + q.size(), src, i < 8 ? h[i] : q[i - 8]});
        done_n++;
        i_requester_node.send_frame(bc, src, code, blk, off, cnt, pl);
        n = 0;
        do begin
            wb(1'b0, 8'h08, 32'h0, r);
            n++;
        end while ((r !== 32'(done_n) || exp_q.size() != 0) && n < 500);
        if (n >= 500) begin
            n_fail++;
            test_done;
        end
    endtask

    initial begin
        arst_n = 1'b0;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i, slow} = '0;
        wb_sel_i = 4'hf;
        repeat (5) @(posedge clock);
        arst_n <= 1'b1;
        repeat (2) @(posedge clock);
        wb(1'b1, 8'h00, 32'h0, r);
        wb(1'b0, 8'h00, 32'h0, r);
        check_reg("ctrl", 32'h0, r);
        wb(1'b1, 8'h00, 32'h1, r);
        wb(1'b0, 8'h0c, 32'h0, r);
        check_reg("geometry", 32'h00040040, r);
        wb(1'b0, 8'h40, 32'h0, r);
        check_reg("unmapped", 32'h0, r);
        d = $random(seed);
        frame(0, 8'h01, 16'h1, 16'h0, 16'h40, '{}, 0, '{});
        frame(0, 8'h02, 16'h1, 16'h3e, 16'h2, '{d[7:0], d[15:8]}, 0, '{});
        frame(0, 8'h04, 16'h1, 16'h3e, 16'h2, '{}, 0, '{d[7:0], d[15:8]});
        slow = 1'b1;
        frame(0, 8'h03, 16'h1, 16'h0, 16'h1, '{d[23:16]}, 0, '{});
        frame(0, 8'h02, 16'h1, 16'h0, 16'h1, '{d[31:24]}, 0, '{});
        rd.push_back(d[23:16] & d[31:24]);
        repeat (63) rd.push_back(8'hff);
        frame(0, 8'h04, 16'h1, 16'h0, 16'h40, '{}, 0, rd);
        frame(0, 8'h04, 16'h1, 16'h3f, 16'h2, '{}, 1, '{});
        frame(0, 8'h02, 16'h4, 16'h0, 16'h1, '{d[7:0]}, 1, '{});
        frame(1, 8'h01, 16'h2, 16'h0, 16'h40, '{}, 0, '{});
        frame(0, 8'h04, 16'h1, 16'h3f, 16'h1, '{}, 0, '{8'hff});
        test_done;
    end
endmodule
